// ===== testbench/pch_card_model.sv
// behavioural flash drive on the card pins
`timescale 1ns/1ps
`default_nettype none
module pch_card_model (
  // bench control
  input wire logic ref_clk, busy,
  input wire logic [5:0] waitCyc,
  // host pins
  input wire logic [25:0] cardAddr_r,
  input wire logic cardEnLow_n_r, cardEnHigh_n_r, memRd_n_r, memWr_n_r,
  input wire logic ioRd_n_r, ioWr_n_r, spaceSel_r, cardReset_r,
  input wire logic [15:0] dataOut_r,
  // drive pins
  output logic [15:0] dataIn = 16'h3c3c,
  output logic readyIrq, wait_n = 1, inAck_n, width16_n, stsChg_n = 1
);
  logic [15:0] mem [0:4095];
  logic [5:0] cnt = 0;
  logic rdyQ = 1;
  wire [11:0] idx = {spaceSel_r, cardAddr_r[10:0]};
  wire strb = !(memRd_n_r & memWr_n_r & ioRd_n_r & ioWr_n_r);
  wire rd = !(memRd_n_r & ioRd_n_r);
  wire wr = !(memWr_n_r & ioWr_n_r);
  // busy doubles as a pending enabled interrupt in i/o mode
  assign readyIrq = !busy
                    && !cardReset_r;
  assign width16_n = cardReset_r;
  assign inAck_n = ioRd_n_r || (cardEnLow_n_r && cardEnHigh_n_r);
  always @(posedge ref_clk) begin
    rdyQ <= readyIrq;
    stsChg_n <= rdyQ == readyIrq;
    cnt <= strb ? cnt + 6'h1 : 6'h0;
    wait_n <= !(strb && cnt < waitCyc);
    // released lanes flip so stale bytes never look valid
    dataIn[7:0] <= rd && !cardEnLow_n_r ? mem[idx][7:0]
                   : ~dataIn[7:0];
    dataIn[15:8] <= rd && !cardEnHigh_n_r ? mem[idx][15:8]
                    : ~dataIn[15:8];
    if (wr && !cardEnLow_n_r) mem[idx][7:0] <= dataOut_r[7:0];
    if (wr && !cardEnHigh_n_r) mem[idx][15:8] <= dataOut_r[15:8];
  end
endmodule
`default_nettype wire

// ===== testbench/pch_host_port_props.sv
// checker for the host port controller pins
`timescale 1ns/1ps
`default_nettype none
`include "pch_host_map.vh"
module pch_host_port_props (
  // requests
  input wire ref_clk, rst_n, clkEn, reqValid, cardResetReq, ioModeSet,
  input wire [1:0] reqLanes,
  // answers and card pins
  input wire wait_n, reqReady_r, rspValid_r, cardReady_r, cardIrq_r,
  input wire ioMode_r, cardEnLow_n_r, cardEnHigh_n_r, memRd_n_r,
  input wire memWr_n_r, ioRd_n_r, ioWr_n_r, cardReset_r, dataOe_r,
  input wire [`PCH_ADDR_W-1:0] cardAddr_r
);
  wire idle = memRd_n_r & memWr_n_r & ioRd_n_r & ioWr_n_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    clkEn && reqReady_r && reqValid && reqLanes && !cardResetReq
      && !ioModeSet;
  endsequence
  sequence s_strobe;
    idle ##[1:4] !idle;
  endsequence
  addr_upper_a: assert property (!cardAddr_r[25:11])
    else $error("high address bits set");
  lane_en_a: assert property (s_take |=>
    {cardEnHigh_n_r, cardEnLow_n_r} == ~$past(reqLanes)) else $error("lanes");
  strobe_go_a: assert property (s_take |=> s_strobe)
    else $error("no strobe");
  rsp_time_a: assert property (
    s_take |=> !rspValid_r [*8] ##[20:900] rspValid_r) else $error("no answer");
  wait_hold_a: assert property (!idle && !wait_n |=> !idle)
    else $error("strobe ended in wait");
  rd_float_a: assert property (
    !(memRd_n_r & ioRd_n_r) |-> !dataOe_r) else $error("bus clash");
  reset_idle_a: assert property (
    cardReset_r |-> idle && !reqReady_r) else $error("access in reset");
  mode_pin_a: assert property (
    $stable(ioMode_r) && ioMode_r == $past(ioMode_r, 2) |->
    !(ioMode_r ? cardReady_r : cardIrq_r)) else $error("pin in wrong mode");
endmodule
bind pch_host_port pch_host_port_props i_props (.*);
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench of the host port controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 0, rst_n = 0, clkEn = 1, reqValid = 0, reqWrite = 0;
  logic reqIo = 0, reqCommon = 0, cardResetReq = 0, ioModeSet = 0;
  logic stsClear = 0, busy = 0;
  logic [1:0] reqLanes = 0;
  logic [5:0] waitCyc = 0;
  logic [25:0] reqAddr = 0, cardAddr_r;
  logic [15:0] reqWdata = 0, rspRdata_r, dataOut_r, dataIn;
  logic reqReady_r, rspValid_r, rspNoAck_r, cardReady_r, cardIrq_r;
  logic stsEvent_r, ioMode_r, width16_r, cardEnLow_n_r, cardEnHigh_n_r;
  logic memRd_n_r, memWr_n_r, ioRd_n_r, ioWr_n_r, spaceSel_r, cardReset_r;
  logic dataOe_r, readyIrq, wait_n, inAck_n, width16_n, stsChg_n;
  int n_fail = 0, checks = 0;
  pch_host_port i_dut (.*);
  pch_card_model i_card (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task ready;
    for (int i = 0; i < 1100 && reqReady_r !== 1'b1; i++) tick;
  endtask
  task acc(input logic [4:0] k, input logic [25:0] a, input logic [15:0] d);
    ready;
    @(posedge ref_clk);
    {reqWrite, reqIo, reqCommon, reqLanes} <= k;
    reqAddr <= a;
    reqWdata <= d;
    reqValid <= 1'b1;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    for (int i = 0; i < 200 && rspValid_r !== 1'b1; i++) tick;
    chk(rspValid_r, 1);
  endtask
  task t_reset;
    ready;
    repeat (3) tick;
    chk({cardReset_r, width16_r, ioMode_r, cardReady_r}, 4'h5);
    $display("t_reset done");
  endtask
  task t_mem;
    acc(5'h17, 26'h3ffffff, 16'hbeef);
    acc(5'h13, 26'h7ff, 16'h1234);
    acc(5'h07, 26'h7ff, 16'h0000);
    chk(rspRdata_r, 16'hbeef);
    acc(5'h01, 26'h7ff, 0);
    chk(rspRdata_r, 16'h0034);
    acc(5'h02, 26'h7ff, 0);
    chk(rspRdata_r, 16'h1200);
    // the ready edge after card reset left the event set, clear it first
    stsClear <= 1'b1;
    tick;
    stsClear <= 1'b0;
    repeat (2) tick;
    chk(stsEvent_r, 1'b0);
    busy <= 1'b1;
    repeat (4) tick;
    chk({cardReady_r, stsEvent_r}, 2'h1);
    busy <= 1'b0;
    repeat (4) tick;
    stsClear <= 1'b1;
    tick;
    stsClear <= 1'b0;
    repeat (2) tick;
    chk(stsEvent_r, 0);
    $display("t_mem done");
  endtask
  task t_io;
    @(posedge ref_clk) ioModeSet <= 1'b1;
    @(posedge ref_clk) ioModeSet <= 1'b0;
    repeat (2) tick;
    chk(ioMode_r, 1);
    waitCyc <= 6'h28;
    acc(5'h1f, 26'h7, 16'h5a5a);
    acc(5'h0d, 26'h7, 16'h0000);
    chk({rspNoAck_r, rspRdata_r}, 17'h0005a);
    busy <= 1'b1;
    repeat (4) tick;
    chk({cardIrq_r, cardReady_r}, 2'h2);
    busy <= 1'b0;
    @(posedge ref_clk) cardResetReq <= 1'b1;
    @(posedge ref_clk) cardResetReq <= 1'b0;
    tick;
    ready;
    chk({cardReset_r, ioMode_r}, 2'h0);
    $display("t_io done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_mem;
    t_io;
    end_of_test;
  end
  initial begin
    #400000;
    n_fail++;
    end_of_test;
  end
endmodule
`default_nettype wire

// ===== verilog/pch_event_latch.v
// sticky latch of card status pin changes
`timescale 1ns/1ps
`default_nettype none
module pch_event_latch (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  input wire clkEn,
  // watched level and clear
  input wire level,
  input wire clear,
  // result
  output reg event_r
);
  reg last_r;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= 1'b1;
      event_r <= 1'b0;
    end else if (clkEn) begin
      last_r <= level;
      // set wins over clear
      if (level != last_r)
        event_r <= 1'b1;
      else if (clear)
        event_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pch_host_map.vh
// constants for the pc card host port controller
`ifndef PCH_HOST_MAP_VH
`define PCH_HOST_MAP_VH
`define PCH_CLK_NS 10
`define PCH_ADDR_W 26
`define PCH_DEC_W 11
`define PCH_DATA_W 16
`define PCH_SETUP_NS 30
`define PCH_SETUP_CYC 3
`define PCH_STROBE_NS 300
`define PCH_STROBE_CYC 30
`define PCH_HOLD_NS 20
`define PCH_HOLD_CYC 2
`define PCH_RESET_US 10
`define PCH_RESET_CYC 1000
`define PCH_SPACE_COMMON 1'b1
`define PCH_SPACE_ATTR 1'b0
`define PCH_LANE_EVEN 0
`define PCH_LANE_ODD 1
`endif

// ===== verilog/pch_host_port.v
// host side controller driving a pc card ata flash drive
// Function
// - low card enable selects even byte lane
// - high card enable selects odd byte lane
// - space select high common, low attribute
// - active-high reset returns drive registers
// - host stretches cycle while wait asserted
`timescale 1ns/1ps
`default_nettype none
`include "pch_host_map.vh"
module pch_host_port (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  input wire clkEn,
  // user request
  input wire reqValid,
  input wire reqWrite,
  input wire reqIo,
  input wire reqCommon,
  input wire [1:0] reqLanes,
  input wire [`PCH_ADDR_W-1:0] reqAddr,
  input wire [`PCH_DATA_W-1:0] reqWdata,
  input wire cardResetReq,
  input wire ioModeSet,
  input wire stsClear,
  // user answer
  output reg reqReady_r,
  output reg rspValid_r,
  output reg [`PCH_DATA_W-1:0] rspRdata_r,
  output reg rspNoAck_r,
  output reg cardReady_r,
  output reg cardIrq_r,
  output reg stsEvent_r,
  output reg ioMode_r,
  output reg width16_r,
  // card pins
  output reg [`PCH_ADDR_W-1:0] cardAddr_r,
  output reg cardEnLow_n_r,
  output reg cardEnHigh_n_r,
  output reg memRd_n_r,
  output reg memWr_n_r,
  output reg ioRd_n_r,
  output reg ioWr_n_r,
  output reg spaceSel_r,
  output reg cardReset_r,
  output reg [`PCH_DATA_W-1:0] dataOut_r,
  output reg dataOe_r,
  input wire [`PCH_DATA_W-1:0] dataIn,
  input wire readyIrq,
  input wire wait_n,
  input wire inAck_n,
  input wire width16_n,
  input wire stsChg_n
);
  localparam [5:0] ST_RST = 6'h01;
  localparam [5:0] ST_IDLE = 6'h02;
  localparam [5:0] ST_SETUP = 6'h04;
  localparam [5:0] ST_STROBE = 6'h08;
  localparam [5:0] ST_WAIT = 6'h10;
  localparam [5:0] ST_HOLD = 6'h20;

  reg [5:0] state_r;
  reg [9:0] cnt_r;
  reg opWrite_r;
  reg opIo_r;
  reg [1:0] opLanes_r;
  reg ackSeen_r;
  wire stsEv;

  // merge byte lanes into the read word, unselected lanes read zero
  function [`PCH_DATA_W-1:0] laneMerge;
    input [1:0] lanes;
    input [`PCH_DATA_W-1:0] d;
    begin
      laneMerge = {lanes[`PCH_LANE_ODD] ? d[15:8] : 8'h00,
                   lanes[`PCH_LANE_EVEN] ? d[7:0] : 8'h00};
    end
  endfunction

  pch_event_latch uStsLatch (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .level(stsChg_n),
    .clear(stsClear),
    .event_r(stsEv)
  );

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RST;
      cnt_r <= 10'h000;
      opWrite_r <= 1'b0;
      opIo_r <= 1'b0;
      opLanes_r <= 2'h0;
      ackSeen_r <= 1'b0;
      reqReady_r <= 1'b0;
      rspValid_r <= 1'b0;
      rspRdata_r <= 16'h0000;
      rspNoAck_r <= 1'b0;
      cardReady_r <= 1'b0;
      cardIrq_r <= 1'b0;
      stsEvent_r <= 1'b0;
      ioMode_r <= 1'b0;
      width16_r <= 1'b0;
      cardAddr_r <= 26'h0000000;
      cardEnLow_n_r <= 1'b1;
      cardEnHigh_n_r <= 1'b1;
      memRd_n_r <= 1'b1;
      memWr_n_r <= 1'b1;
      ioRd_n_r <= 1'b1;
      ioWr_n_r <= 1'b1;
      spaceSel_r <= `PCH_SPACE_COMMON;
      cardReset_r <= 1'b1;
      dataOut_r <= 16'h0000;
      dataOe_r <= 1'b0;
    end else if (clkEn) begin
      rspValid_r <= 1'b0;
      stsEvent_r <= stsEv;
      // ready pin is ready/busy in memory mode, irq in i/o mode
      cardReady_r <= !ioMode_r && readyIrq;
      // irq active low, pin floats high when not pending or disabled
      cardIrq_r <= ioMode_r && !readyIrq;
      width16_r <= !width16_n;
      case (state_r)
        ST_RST: begin
          // hold card reset for the minimum pulse width
          cardReset_r <= 1'b1;
          ioMode_r <= 1'b0;
          if (cnt_r == `PCH_RESET_CYC - 1) begin
            cnt_r <= 10'h000;
            cardReset_r <= 1'b0;
            state_r <= ST_IDLE;
            reqReady_r <= 1'b1;
          end else
            cnt_r <= cnt_r + 10'h001;
        end
        ST_IDLE: begin
          if (cardResetReq) begin
            reqReady_r <= 1'b0;
            cnt_r <= 10'h000;
            state_r <= ST_RST;
          end else if (ioModeSet) begin
            ioMode_r <= 1'b1;
          end else if (reqValid && reqLanes != 2'h0) begin
            reqReady_r <= 1'b0;
            opWrite_r <= reqWrite;
            opIo_r <= reqIo;
            opLanes_r <= reqLanes;
            ackSeen_r <= 1'b0;
            // upper lines are ignored by the card, drive them low
            cardAddr_r <= {15'h0000, reqAddr[`PCH_DEC_W-1:0]};
            spaceSel_r <= reqCommon;
            cardEnLow_n_r <= !reqLanes[`PCH_LANE_EVEN];
            cardEnHigh_n_r <= !reqLanes[`PCH_LANE_ODD];
            dataOut_r <= reqWdata;
            dataOe_r <= reqWrite;
            cnt_r <= 10'h000;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_r == `PCH_SETUP_CYC - 1) begin
            cnt_r <= 10'h000;
            memRd_n_r <= !(!opIo_r && !opWrite_r);
            memWr_n_r <= !(!opIo_r && opWrite_r);
            ioRd_n_r <= !(opIo_r && !opWrite_r);
            ioWr_n_r <= !(opIo_r && opWrite_r);
            state_r <= ST_STROBE;
          end else
            cnt_r <= cnt_r + 10'h001;
        end
        ST_STROBE: begin
          if (!inAck_n)
            ackSeen_r <= 1'b1;
          if (cnt_r == `PCH_STROBE_CYC - 1) begin
            cnt_r <= 10'h000;
            state_r <= ST_WAIT;
          end else
            cnt_r <= cnt_r + 10'h001;
        end
        ST_WAIT: begin
          if (!inAck_n)
            ackSeen_r <= 1'b1;
          // stretch the strobe until the card releases wait
          if (wait_n) begin
            memRd_n_r <= 1'b1;
            memWr_n_r <= 1'b1;
            ioRd_n_r <= 1'b1;
            ioWr_n_r <= 1'b1;
            rspRdata_r <= opWrite_r ? 16'h0000 :
                          laneMerge(opLanes_r, dataIn);
            rspNoAck_r <= opIo_r && !opWrite_r && !ackSeen_r
                          && inAck_n;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_r == `PCH_HOLD_CYC - 1) begin
            cnt_r <= 10'h000;
            cardEnLow_n_r <= 1'b1;
            cardEnHigh_n_r <= 1'b1;
            dataOe_r <= 1'b0;
            rspValid_r <= 1'b1;
            reqReady_r <= 1'b1;
            state_r <= ST_IDLE;
          end else
            cnt_r <= cnt_r + 10'h001;
        end
        default: begin
          state_r <= ST_RST;
          cnt_r <= 10'h000;
        end
      endcase
    end
  end
endmodule
`default_nettype wire
